// ### core/p2sd_top.v
// Port 2 PHY strap default loader with software override
`timescale 1ns/1ps
`default_nettype none
`include "p2sd_defs.vh"

module p2sd_top #(
    parameter SETTLE_CYCLES = `P2SD_SETTLE_CYCLES
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire p2_autonegotiation_pin_i,
    input wire p2_speed_pin_i,
    input wire p2_duplex_pin_i,
    input wire sw_ctrl_wr_i,
    input wire sw_an_i,
    input wire sw_rate_i,
    input wire sw_duplex_i,
    input wire sw_adv_wr_i,
    input wire sw_adv_10fd_i,
    input wire sw_adv_10hd_i,
    input wire sw_mode_wr_i,
    input wire [`P2SD_MODE_W-1:0] sw_mode_i,
    output reg autonegotiation_enable_bit_o,
    output reg rate_select_low_bit_o,
    output reg halffull_mode_bit_o,
    output reg adv_10fd_o,
    output reg adv_10hd_o,
    output reg [`P2SD_MODE_W-1:0] special_mode_o,
    output reg [2:0] strap_latched_o,
    output reg defaults_valid_o,
    output reg sw_override_o
);

localparam [1:0] ST_WAIT = `P2SD_ST_WAIT;
localparam [1:0] ST_LOAD = `P2SD_ST_LOAD;
localparam [1:0] ST_RUN = `P2SD_ST_RUN;
localparam CNT_W = 8;
// Settle counts above 256 do not fit the counter
localparam integer SETTLE_LAST_I = SETTLE_CYCLES - 1;
localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[CNT_W-1:0];

wire [2:0] strap_lvl;
wire strap_stable;
wire [2:0] strap_pins;
wire sw_any_wr;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [CNT_W-1:0] settle_r;
reg [CNT_W-1:0] settle_nxt;

reg dflt_an;
reg dflt_rate;
reg dflt_duplex;
reg dflt_10fd;
reg dflt_10hd;
reg [`P2SD_MODE_W-1:0] dflt_mode;

// Pin order sets the bit order of strap_latched_o
assign strap_pins = {p2_autonegotiation_pin_i, p2_speed_pin_i,
    p2_duplex_pin_i};

// Any strobe marks the bits as software owned, even a same value
assign sw_any_wr = sw_ctrl_wr_i | sw_adv_wr_i | sw_mode_wr_i;

// Straps are pins from outside the clock domain
p2sd_strap_sync #(
    .WIDTH(3)
) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(strap_pins),
    .level_o(strap_lvl),
    .stable_o(strap_stable)
);

// Mode field: all-capable under autoneg, else forced speed and duplex
function [`P2SD_MODE_W-1:0] p2sd_mode_of;
    input an;
    input rate;
    input dup;
    begin
        if (an)
        begin
            p2sd_mode_of = `P2SD_MODE_AN_ALL;
        end
        else
        begin
            p2sd_mode_of = {`P2SD_MODE_FORCED_MSB, rate, dup};
        end
    end
endfunction

// Defaults derived from the synchronised strap levels
always @*
begin
    dflt_an = strap_lvl[2];
    // Autoneg brings up the fastest forced fallback
    dflt_rate = strap_lvl[2] | strap_lvl[1];
    dflt_duplex = strap_lvl[2] | strap_lvl[0];
    // 10BASE-T is advertised only when 10 Mbps is reachable
    dflt_10hd = strap_lvl[2] | ~strap_lvl[1];
    dflt_10fd = strap_lvl[2] | (~strap_lvl[1] & strap_lvl[0]);
    dflt_mode = p2sd_mode_of(strap_lvl[2], strap_lvl[1],
        strap_lvl[0]);
end

// Loader sequencing: wait for straps to settle, load once, then run
always @*
begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
        ST_WAIT:
        begin
            if (!strap_stable)
            begin
                settle_nxt = {CNT_W{1'b0}};
            end
            else if (settle_r == SETTLE_LAST)
            begin
                state_nxt = ST_LOAD;
            end
            else
            begin
                settle_nxt = settle_r + 1'b1;
            end
        end
        ST_LOAD:
        begin
            state_nxt = ST_RUN;
        end
        ST_RUN:
        begin
            // Only a fresh reset reloads the straps
            state_nxt = ST_RUN;
        end
        default:
        begin
            state_nxt = ST_WAIT;
            settle_nxt = {CNT_W{1'b0}};
        end
    endcase
end

always @(posedge mclk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        state_r <= ST_WAIT;
        settle_r <= {CNT_W{1'b0}};
    end
    else if (ce_i)
    begin
        state_r <= state_nxt;
        settle_r <= settle_nxt;
    end
end

// Register bits: strap values at load, software values afterwards
always @(posedge mclk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        autonegotiation_enable_bit_o <= `P2SD_RST_AN;
        rate_select_low_bit_o <= `P2SD_RST_SPEED;
        halffull_mode_bit_o <= `P2SD_RST_DUPLEX;
        {adv_10fd_o, adv_10hd_o} <= `P2SD_RST_ADV;
        special_mode_o <= `P2SD_RST_MODE;
        strap_latched_o <= 3'h0;
        defaults_valid_o <= 1'b0;
        sw_override_o <= 1'b0;
    end
    else if (ce_i)
    begin
        if (state_r == ST_LOAD)
        begin
            autonegotiation_enable_bit_o <= dflt_an;
            rate_select_low_bit_o <= dflt_rate;
            halffull_mode_bit_o <= dflt_duplex;
            adv_10fd_o <= dflt_10fd;
            adv_10hd_o <= dflt_10hd;
            special_mode_o <= dflt_mode;
            strap_latched_o <= strap_lvl;
            defaults_valid_o <= 1'b1;
        end
        else if (state_r == ST_RUN)
        begin
            // Writes before the load would be overwritten, so they are ignored until run
            if (sw_ctrl_wr_i)
            begin
                autonegotiation_enable_bit_o <= sw_an_i;
                rate_select_low_bit_o <= sw_rate_i;
                halffull_mode_bit_o <= sw_duplex_i;
            end
            if (sw_adv_wr_i)
            begin
                adv_10fd_o <= sw_adv_10fd_i;
                adv_10hd_o <= sw_adv_10hd_i;
            end
            if (sw_mode_wr_i)
            begin
                special_mode_o <= sw_mode_i;
            end
            if (sw_any_wr)
            begin
                sw_override_o <= 1'b1;
            end
        end
    end
end

endmodule // p2sd_top

`default_nettype wire

// ### core/p2sd_defs.vh
// Constants for the port 2 strap default loader
`ifndef P2SD_DEFS_VH
`define P2SD_DEFS_VH

// Advertisement field positions
`define P2SD_ADV_10FD_BIT 6
`define P2SD_ADV_10HD_BIT 5

// Special-mode field width and encodings
`define P2SD_MODE_W 3
`define P2SD_MODE_AN_ALL 3'h7
`define P2SD_MODE_FORCED_MSB 1'h0

// Values held until the straps are loaded
`define P2SD_RST_AN 1'h0
`define P2SD_RST_SPEED 1'h0
`define P2SD_RST_DUPLEX 1'h0
`define P2SD_RST_ADV 2'h0
`define P2SD_RST_MODE 3'h0

// Strap settle time after the synchroniser reports stable, in mclk cycles
`define P2SD_SETTLE_CYCLES 8

// Loader states
`define P2SD_ST_WAIT 2'h0
`define P2SD_ST_LOAD 2'h1
`define P2SD_ST_RUN 2'h2

`endif

// ### core/p2sd_strap_sync.v
// Three-stage strap synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module p2sd_strap_sync #(
    parameter WIDTH = 3
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [WIDTH-1:0] pin_i,
    output reg [WIDTH-1:0] level_o,
    output reg stable_o
);

reg [WIDTH-1:0] stg1_r;
reg [WIDTH-1:0] stg2_r;
reg [WIDTH-1:0] stg3_r;
reg [1:0] fill_r;

// First stage feeds only the second stage
always @(posedge mclk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        stg1_r <= {WIDTH{1'b0}};
        stg2_r <= {WIDTH{1'b0}};
        stg3_r <= {WIDTH{1'b0}};
        level_o <= {WIDTH{1'b0}};
        stable_o <= 1'b0;
        fill_r <= 2'h0;
    end
    else if (ce_i)
    begin
        stg1_r <= pin_i;
        stg2_r <= stg1_r;
        stg3_r <= stg2_r;
        // Reset zeros in the chain would pass as an agreed level
        if (fill_r != 2'h3)
        begin
            fill_r <= fill_r + 2'h1;
        end
        if ((fill_r == 2'h3) && (stg2_r == stg3_r))
        begin
            level_o <= stg3_r;
        end
        stable_o <= (fill_r == 2'h3) && (stg2_r == stg3_r);
    end
end

endmodule // p2sd_strap_sync

`default_nettype wire

// ### sim/p2sd_assertions.sv
// Checker for the port 2 strap default loader
`timescale 1ns/1ps
`default_nettype none
module p2sd_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sw_ctrl_wr_i,
    input wire logic sw_an_i,
    input wire logic sw_rate_i,
    input wire logic sw_duplex_i,
    input wire logic sw_mode_wr_i,
    input wire logic [2:0] sw_mode_i,
    input wire logic autonegotiation_enable_bit_o,
    input wire logic rate_select_low_bit_o,
    input wire logic halffull_mode_bit_o,
    input wire logic adv_10fd_o,
    input wire logic adv_10hd_o,
    input wire logic [2:0] special_mode_o,
    input wire logic [2:0] strap_latched_o,
    input wire logic defaults_valid_o,
    input wire logic sw_override_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire [2:0] s = strap_latched_o;
    wire ld = defaults_valid_o;
    AST_AN: assert property ($rose(ld) |->
        autonegotiation_enable_bit_o == s[2])
        else $error("an default wrong");
    AST_AUTO: assert property ($rose(ld) && s[2] |->
        rate_select_low_bit_o && halffull_mode_bit_o && adv_10fd_o
        && adv_10hd_o && special_mode_o == 3'h7)
        else $error("autoneg shaping wrong");
    AST_RATE: assert property ($rose(ld) |->
        rate_select_low_bit_o == (s[2] | s[1]))
        else $error("rate default wrong");
    AST_ADV: assert property ($rose(ld) |->
        adv_10hd_o == (s[2] | ~s[1])
        && adv_10fd_o == (s[2] | (~s[1] & s[0])))
        else $error("advert default wrong");
    AST_DUP: assert property ($rose(ld) |->
        halffull_mode_bit_o == (s[2] | s[0]))
        else $error("duplex default wrong");
    AST_MODE: assert property ($rose(ld) |->
        special_mode_o == (s[2] ? 3'h7 : {1'h0, s[1:0]}))
        else $error("mode default wrong");
    AST_HOLD: assert property (ld |=>
        ld && $stable(strap_latched_o))
        else $error("load not held");
    AST_EARLY: assert property (!ld |-> !sw_override_o)
        else $error("early write taken");
    AST_SWCTRL: assert property (ld && ce_i && sw_ctrl_wr_i |=>
        sw_override_o
        && autonegotiation_enable_bit_o == $past(sw_an_i)
        && rate_select_low_bit_o == $past(sw_rate_i)
        && halffull_mode_bit_o == $past(sw_duplex_i))
        else $error("ctrl write lost");
    AST_SWMODE: assert property (ld && ce_i && sw_mode_wr_i |=>
        sw_override_o && special_mode_o == $past(sw_mode_i))
        else $error("mode write lost");
    cover property ($rose(ld));
    cover property ($rose(ld) && s[2]);
    cover property (ld && ce_i && sw_ctrl_wr_i);
endmodule // p2sd_chk
bind p2sd_top p2sd_chk u_chk (.*);
`default_nettype wire

// ### sim/p2sd_top_bench.sv
// Bench for the port 2 strap default loader
`timescale 1ns/1ps
`default_nettype none
module p2sd_top_bench;
    logic mclk_i = 0;
    logic rst_n_i = 0;
    logic ce_i = 1;
    logic [2:0] pin = 0;
    logic cw = 0, aw = 0, mw = 0;
    logic [2:0] cd = 0, md = 0;
    logic [1:0] ad = 0;
    wire [7:0] obs;
    wire [2:0] lat;
    wire dv, ovr;
    int fail_count = 0;
    int checked = 0;
    localparam int SETTLE = 4;
    // Short settle keeps eight reloads cheap
    p2sd_top #(.SETTLE_CYCLES(SETTLE)) dut (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .ce_i(ce_i), .p2_autonegotiation_pin_i(pin[2]),
        .p2_speed_pin_i(pin[1]), .p2_duplex_pin_i(pin[0]),
        .sw_ctrl_wr_i(cw), .sw_an_i(cd[2]), .sw_rate_i(cd[1]),
        .sw_duplex_i(cd[0]), .sw_adv_wr_i(aw), .sw_adv_10fd_i(ad[1]),
        .sw_adv_10hd_i(ad[0]), .sw_mode_wr_i(mw), .sw_mode_i(md),
        .autonegotiation_enable_bit_o(obs[7]), .rate_select_low_bit_o(obs[6]),
        .halffull_mode_bit_o(obs[5]), .adv_10fd_o(obs[4]),
        .adv_10hd_o(obs[3]), .special_mode_o(obs[2:0]),
        .strap_latched_o(lat), .defaults_valid_o(dv), .sw_override_o(ovr));
    initial forever #2.5 mclk_i = ~mclk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] derive(input logic [2:0] p);
        derive = {p[2], p[2] | p[1], p[2] | p[0], p[2] | (~p[1] & p[0]),
            p[2] | ~p[1], p[2] ? 3'h7 : {1'h0, p[1:0]}};
    endfunction
    task automatic load_case(input logic [2:0] p);
        int n;
        @(negedge mclk_i);
        rst_n_i = 0;
        pin = p;
        repeat (20) @(negedge mclk_i);
        rst_n_i = 1;
        cw = 1;
        cd = 3'h5;
        @(negedge mclk_i);
        cw = 0;
        for (n = 0; n < 40 && dv !== 1'b1; n++) @(negedge mclk_i);
        // Four sync edges, the settle count, the load edge, less the write cycle before the loop
        chk(n[7:0], 8'(SETTLE + 4));
        chk({dv, ovr, 3'h0, lat}, {2'h2, 3'h0, p});
        chk(obs, derive(p));
    endtask
    task automatic sw_case;
        pin = 3'h0;
        repeat (30) @(negedge mclk_i);
        chk({obs[7:1], ovr}, 8'hfe);
        chk({dv, 4'h0, lat}, 8'h87);
        ce_i = 0;
        cw = 1;
        cd = 3'h0;
        @(negedge mclk_i);
        ce_i = 1;
        cw = 0;
        @(negedge mclk_i);
        chk(obs, 8'hff);
        cw = 1;
        aw = 1;
        mw = 1;
        cd = 3'h2;
        ad = 2'h1;
        md = 3'h5;
        @(negedge mclk_i);
        cw = 0;
        aw = 0;
        mw = 0;
        chk(obs, 8'h4d);
        chk({7'h0, ovr}, 8'h01);
        @(negedge mclk_i);
        mw = 1;
        md = 3'h2;
        cd = 3'h7;
        ad = 2'h2;
        @(negedge mclk_i);
        mw = 0;
        chk(obs, 8'h4a);
        aw = 1;
        @(negedge mclk_i);
        aw = 0;
        chk(obs, 8'h52);
    endtask
    task complete_run;
        $display("Checked %0d, failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 8; i++) load_case(i[2:0]);
        sw_case;
        complete_run;
    end
    initial
    begin
        #20000;
        fail_count++;
        complete_run;
    end
endmodule // p2sd_top_bench
`default_nettype wire
